//--- verilog/reactive_energy_accumulator.sv
// Reactive energy accumulator with Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module reactive_energy_accumulator
  import reactive_energy_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Power inputs from filter path
  input wire logic signed [POWER_W-1:0] reactive_power_i,
  input wire logic active_power_neg_i,
  // Waveform output
  output logic signed [POWER_W-1:0] wave_data_o,
  output logic wave_valid_o,
  // Interrupt request toward the core
  output logic irq_o
);
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] wave_sel_reg;
  logic [7:0] noload_cfg_reg;
  logic [7:0] acc_cfg_reg;
  logic [GAIN_W-1:0] gain_reg;
  logic [OFFSET_W-1:0] offset_reg;
  logic [7:0] divisor_reg;
  logic [7:0] irq_en_low_reg;
  logic [7:0] irq_en_mid_reg;
  logic [7:0] irq_en_high_reg;
  logic [7:0] irq_st_low_reg;
  logic [7:0] irq_st_mid_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic [2:0] phase_reg;
  logic sign_prev_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  logic signed [POWER_W-1:0] trimmed;
  logic signed [POWER_W-1:0] divided;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic rd_rc;
  logic tick;
  logic below;
  logic [POWER_W-1:0] mag;
  logic [POWER_W-1:0] thr;
  acc_mode_t mode;
  logic signed [ACC_W-1:0] addend;
  logic signed [ACC_W-1:0] acc_next;
  logic [ENERGY_W-1:0] top_old;
  logic [ENERGY_W-1:0] top_new;
  logic ev_half;
  logic ev_wrap;
  logic ev_sign;

  // --------------------------------------------------------------------------
  // Processing chain
  // --------------------------------------------------------------------------
  power_trim u_trim (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .power_i(reactive_power_i),
    .gain_i(gain_reg),
    .offset_i(offset_reg),
    .power_o(trimmed)
  );

  energy_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .power_i(trimmed),
    .divisor_i(divisor_reg),
    .power_o(divided)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign idx = adr_i[9:2];
  assign req = cyc_i && stb_i && !ack_reg;
  assign wr = req && we_i && sel_i[0];
  assign rd_rc = req && !we_i && (idx == IDX_ENERGY_RC);
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  // Read data registered; slave answers one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_reg <= 32'h0000_0000;
    else if (req && !we_i)
    begin
      unique case (idx)
        IDX_ENERGY, IDX_ENERGY_RC: dat_reg <= {8'h00, acc_reg[ACC_W-1 -: ENERGY_W]};
        IDX_WAVE_SEL: dat_reg <= {24'h0, wave_sel_reg};
        IDX_NOLOAD_CFG: dat_reg <= {24'h0, noload_cfg_reg};
        IDX_ACC_CFG: dat_reg <= {24'h0, acc_cfg_reg};
        IDX_GAIN: dat_reg <= {20'h0, gain_reg};
        IDX_OFFSET: dat_reg <= {16'h0, offset_reg};
        IDX_DIVISOR: dat_reg <= {24'h0, divisor_reg};
        IDX_IRQ_EN_LOW: dat_reg <= {24'h0, irq_en_low_reg};
        IDX_IRQ_EN_MID: dat_reg <= {24'h0, irq_en_mid_reg};
        IDX_IRQ_EN_HIGH: dat_reg <= {24'h0, irq_en_high_reg};
        IDX_IRQ_ST_LOW: dat_reg <= {24'h0, irq_st_low_reg};
        IDX_IRQ_ST_MID: dat_reg <= {24'h0, irq_st_mid_reg};
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Byte lane 0 only; wider registers take their upper bits from lane 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wave_sel_reg <= 8'h00;
      noload_cfg_reg <= 8'h00;
      acc_cfg_reg <= 8'h00;
      gain_reg <= 12'h000;
      offset_reg <= 16'h0000;
      divisor_reg <= 8'h00;
      irq_en_low_reg <= 8'h00;
      irq_en_mid_reg <= 8'h00;
      irq_en_high_reg <= 8'h00;
    end
    else if (wr)
    begin
      unique case (idx)
        IDX_WAVE_SEL: wave_sel_reg <= dat_i[7:0];
        IDX_NOLOAD_CFG: noload_cfg_reg <= dat_i[7:0];
        IDX_ACC_CFG: acc_cfg_reg <= dat_i[7:0];
        IDX_GAIN: gain_reg <= sel_i[1] ? dat_i[11:0] : {gain_reg[11:8], dat_i[7:0]};
        IDX_OFFSET: offset_reg <= sel_i[1] ? dat_i[15:0] : {offset_reg[15:8], dat_i[7:0]};
        IDX_DIVISOR: divisor_reg <= dat_i[7:0];
        IDX_IRQ_EN_LOW: irq_en_low_reg <= dat_i[7:0];
        IDX_IRQ_EN_MID: irq_en_mid_reg <= dat_i[7:0];
        IDX_IRQ_EN_HIGH: irq_en_high_reg <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // No-load, mode and accumulation
  // --------------------------------------------------------------------------
  assign mag = divided[POWER_W-1] ? POWER_W'(-divided) : divided;

  always_comb
  begin
    unique case (noload_cfg_reg[NL_LSB +: 2])
      2'b01: thr = NL_THR_1;
      2'b10: thr = NL_THR_2;
      2'b11: thr = NL_THR_3;
      default: thr = '0;
    endcase
  end

  assign below = (thr != '0) && (mag < thr);

  always_comb
  begin
    if (acc_cfg_reg[BIT_ABSOLUTE])
      mode = ACC_ABS;
    else if (acc_cfg_reg[BIT_ANTITAMPER])
      mode = ACC_TAMPER;
    else
      mode = ACC_SIGNED;
  end

  always_comb
  begin
    unique case (mode)
      ACC_ABS: addend = ACC_W'($signed({1'b0, mag}));
      ACC_TAMPER: addend = active_power_neg_i ? -ACC_W'(divided) : ACC_W'(divided);
      ACC_SIGNED: addend = ACC_W'(divided);
    endcase
  end

  assign tick = (phase_reg == 3'(ACC_PERIOD - 1));
  // Plain sum wraps naturally in the 24-bit view
  assign acc_next = acc_reg + ((tick && !below) ? addend : '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase_reg <= 3'h0;
    else
      phase_reg <= tick ? 3'h0 : phase_reg + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_reg <= '0;
    else if (rd_rc)
      acc_reg <= {ENERGY_W'(0), acc_next[ACC_W-ENERGY_W-1:0]};
    else
      acc_reg <= acc_next;
  end

  // --------------------------------------------------------------------------
  // Events and status
  // --------------------------------------------------------------------------
  assign top_old = acc_reg[ACC_W-1 -: ENERGY_W];
  assign top_new = acc_next[ACC_W-1 -: ENERGY_W];
  // Overflow and underflow leave a differing top pair; a crossing through zero does not
  assign ev_wrap = (top_old[23] != top_new[23]) && (top_old[22] != top_old[23]);
  assign ev_half = (top_old[22] ^ top_old[23]) == 1'b0
      && (top_new[22] ^ top_new[23]) == 1'b1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sign_prev_reg <= 1'b0;
    else
      sign_prev_reg <= trimmed[POWER_W-1];
  end

  assign ev_sign = acc_cfg_reg[BIT_DIRECTION]
      ? (sign_prev_reg && !trimmed[POWER_W-1])
      : (!sign_prev_reg && trimmed[POWER_W-1]);

  // Writing one clears a flag; a new event in the same cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_st_low_reg <= 8'h00;
    else
    begin
      if (wr && idx == IDX_IRQ_ST_LOW)
        irq_st_low_reg <= irq_st_low_reg & ~dat_i[7:0];
      if (ev_sign)
        irq_st_low_reg[BIT_SIGN] <= 1'b1;
      if (below)
        irq_st_low_reg[BIT_IDLE] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_st_mid_reg <= 8'h00;
    else
    begin
      if (wr && idx == IDX_IRQ_ST_MID)
        irq_st_mid_reg <= irq_st_mid_reg & ~dat_i[7:0];
      if (ev_half)
        irq_st_mid_reg[BIT_HALF] <= 1'b1;
      if (ev_wrap)
        irq_st_mid_reg[BIT_WRAP] <= 1'b1;
    end
  end

  assign irq_o = |(irq_st_low_reg & irq_en_low_reg)
      || |(irq_st_mid_reg & irq_en_mid_reg);

  // --------------------------------------------------------------------------
  // Waveform sampling
  // --------------------------------------------------------------------------
  logic [15:0] wave_cnt_reg;
  logic [15:0] wave_limit;
  assign wave_limit = 16'((WAVE_BASE_DIV << wave_sel_reg[1:0]) - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !irq_en_high_reg[BIT_WAVE_EN])
    begin
      wave_cnt_reg <= 16'h0000;
      wave_valid_o <= 1'b0;
      wave_data_o <= '0;
    end
    else
    begin
      wave_valid_o <= (wave_cnt_reg == wave_limit);
      wave_cnt_reg <= (wave_cnt_reg >= wave_limit) ? 16'h0000 : wave_cnt_reg + 16'h0001;
      if (wave_cnt_reg == wave_limit)
        wave_data_o <= trimmed;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> !tick [*4] ##1 tick) else $error("accumulate tick not every five clocks");
  a_hold_between: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick && !rd_rc |=> acc_reg == $past(acc_reg)) else $error("accumulator moved off tick");
  a_noload_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    below && !rd_rc |=> acc_reg == $past(acc_reg)) else $error("accumulated under no load");
  a_idle_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    below |=> irq_st_low_reg[BIT_IDLE]) else $error("idle flag not set");
  a_sign_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !acc_cfg_reg[BIT_DIRECTION] && !sign_prev_reg && trimmed[POWER_W-1]
    |=> irq_st_low_reg[BIT_SIGN]) else $error("sign flag missed");
  a_irq_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_st_low_reg[BIT_SIGN] && irq_en_low_reg[BIT_SIGN] |-> irq_o)
    else $error("sign interrupt not pending");
  a_clear_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_rc |=> acc_reg[ACC_W-1 -: ENERGY_W] == '0) else $error("clear on read failed");
  a_abs_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_cfg_reg[BIT_ABSOLUTE] && tick && !below && !rd_rc |=> acc_reg >= $past(acc_reg)
    || $past(acc_reg[ACC_W-1:ACC_W-2]) == 2'b01) else $error("absolute mode decreased");
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
endmodule
`default_nettype wire

//--- verilog/reactive_energy_pkg.sv
// Constants, register map and field layout of the reactive energy accumulator
// ----------------------------------------------------------------------------
// What this block does
// - Reactive power scaled by one plus signed 12-bit gain trim over 4096.
// - Signed 16-bit offset trim is added to reactive power.
// - 256 counts of offset trim equal one sample LSB.
// - Positive angle gives positive reactive power, negative angle negative.
// - Direction bit clear: positive-to-negative transition sets sign-change flag.
// - Direction bit set: negative-to-positive transition sets sign-change flag.
// - Sign-change flag with its enable holds interrupt until flag cleared.
// - Below no-load threshold: no accumulation, idle flag set.
// - Idle flag with its enable holds interrupt until flag cleared.
// - Select 00 off; 01, 10, 11 choose three falling thresholds.
// - Processed power added to 49-bit signed accumulator every five clocks.
// - Upper 24 accumulator bits readable; plain read does not clear.
// - Both mode bits clear: signed accumulation.
// - Both mode bits set: absolute accumulation wins.
// - Antitamper: add when active power positive, subtract when negative.
// - Absolute mode accumulates magnitude of reactive power.
// - Divide by 8-bit unsigned divisor; zero means one.
// - Clear-on-read view returns energy then clears upper 24 bits.
// - Energy value wraps in both directions and keeps counting.
// - Half-full and overflow events flag and interrupt per enables.
// - Waveform output gives reactive samples at four selectable rates.
// ----------------------------------------------------------------------------
package reactive_energy_pkg;
  // Register byte addresses are four times the printed index
  localparam logic [7:0] IDX_ENERGY = 8'h04;
  localparam logic [7:0] IDX_ENERGY_RC = 8'h05;
  localparam logic [7:0] IDX_WAVE_SEL = 8'h0D;
  localparam logic [7:0] IDX_NOLOAD_CFG = 8'h0E;
  localparam logic [7:0] IDX_ACC_CFG = 8'h0F;
  localparam logic [7:0] IDX_GAIN = 8'h1E;
  localparam logic [7:0] IDX_OFFSET = 8'h21;
  localparam logic [7:0] IDX_DIVISOR = 8'h25;
  localparam logic [7:0] IDX_IRQ_EN_LOW = 8'hD9;
  localparam logic [7:0] IDX_IRQ_EN_MID = 8'hDA;
  localparam logic [7:0] IDX_IRQ_EN_HIGH = 8'hDB;
  localparam logic [7:0] IDX_IRQ_ST_LOW = 8'hDC;
  localparam logic [7:0] IDX_IRQ_ST_MID = 8'hDD;
  // Field positions
  localparam int BIT_IDLE = 1;
  localparam int BIT_SIGN = 4;
  localparam int BIT_ANTITAMPER = 2;
  localparam int BIT_ABSOLUTE = 3;
  localparam int BIT_DIRECTION = 5;
  localparam int BIT_WAVE_EN = 5;
  localparam int BIT_HALF = 0;
  localparam int BIT_WRAP = 1;
  localparam int NL_LSB = 2;
  // Widths and scale
  localparam int ACC_W = 49;
  localparam int ENERGY_W = 24;
  localparam int GAIN_W = 12;
  localparam int GAIN_SHIFT = 12;
  localparam int OFFSET_W = 16;
  localparam int OFFSET_SHIFT = 8;
  localparam int POWER_W = 24;
  localparam int ACC_PERIOD = 5;
  // Wave rate divisors from 200 MHz to 25.6 kSPS base (rounded down)
  localparam int CLK_HZ = 200000000;
  localparam int WAVE_BASE_SPS = 25600;
  localparam int WAVE_BASE_DIV = CLK_HZ / WAVE_BASE_SPS;
  // No-load thresholds as magnitudes of the scaled power, arbitrary full scale
  localparam logic [POWER_W-1:0] NL_THR_1 = 24'h000141;
  localparam logic [POWER_W-1:0] NL_THR_2 = 24'h0000A0;
  localparam logic [POWER_W-1:0] NL_THR_3 = 24'h00004F;
  typedef enum logic [1:0] {ACC_SIGNED, ACC_TAMPER, ACC_ABS} acc_mode_t;
endpackage

//--- verilog/power_trim.sv
// Gain and offset trim stage for the reactive power sample
`timescale 1ns/10ps
`default_nettype none
module power_trim
  import reactive_energy_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic signed [POWER_W-1:0] power_i,
  input wire logic [GAIN_W-1:0] gain_i,
  input wire logic [OFFSET_W-1:0] offset_i,
  output logic signed [POWER_W-1:0] power_o
);
  logic signed [POWER_W+GAIN_W:0] prod;
  logic signed [POWER_W+1:0] sum;
  assign prod = power_i * $signed(gain_i);
  // Offset is in 1/256 LSB units; fraction truncated toward minus infinity
  assign sum = (POWER_W+2)'(power_i) + (POWER_W+2)'(prod >>> GAIN_SHIFT)
      + (POWER_W+2)'($signed(offset_i) >>> OFFSET_SHIFT);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      power_o <= '0;
    else
      power_o <= sum[POWER_W-1:0];
  end
endmodule
`default_nettype wire

//--- verilog/energy_divider.sv
// Divide-by-N prescaler for processed power before accumulation
`timescale 1ns/10ps
`default_nettype none
module energy_divider
  import reactive_energy_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic signed [POWER_W-1:0] power_i,
  input wire logic [7:0] divisor_i,
  output logic signed [POWER_W-1:0] power_o
);
  logic [7:0] div_eff;
  // Zero is treated as one so the path never stalls
  assign div_eff = (divisor_i == 8'h00) ? 8'h01 : divisor_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      power_o <= '0;
    else
      power_o <= POWER_W'(power_i / $signed({1'b0, div_eff}));
  end
endmodule
`default_nettype wire

//--- verif/core_bus_model.sv
// Core-side Wishbone master model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module core_bus_model
(
  // Clock
  input wire logic clk_i,
  // Wishbone master
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  int timeouts = 0;
  initial
  begin
    cyc_o = 1'h0;
    stb_o = 1'h0;
    we_o = 1'h0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end
  // ----------------------------------------
  // One classic cycle, held until ack is seen
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd_o);
    int n;
    n = 0;
    cyc_o <= 1'h1;
    stb_o <= 1'h1;
    we_o <= w;
    adr_o <= {idx, 2'h0};
    sel_o <= 4'hF;
    dat_o <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'h1 && n < 50);
    rd_o = dat_i;
    if (n >= 50)
      timeouts++;
    // Released lines show inverted data so stale values never pass for fresh ones
    cyc_o <= 1'h0;
    stb_o <= 1'h0;
    we_o <= 1'h0;
    dat_o <= ~wd;
    @(posedge clk_i);
  endtask
  // Flags are cleared by writing ones to the status register
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] unused;
    xfer(1'h1, idx, wd, unused);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] rd_o);
    xfer(1'h0, idx, 32'h00000000, rd_o);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_reactive_energy_accumulator.sv
// Self-checking testbench for the reactive energy accumulator
`timescale 1ns/10ps
`default_nettype none
module tb_reactive_energy_accumulator;
  import reactive_energy_pkg::*;
  // ----------------------------------------
  // Clock, stimulus and wiring
  // ----------------------------------------
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic act_neg = 1'h0;
  logic signed [POWER_W-1:0] pwr = 24'h000000;
  logic cyc, stb, we, ack, irq, wv;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rdat, got;
  logic signed [POWER_W-1:0] wave;
  int err_count = 0;
  int compares = 0;
  int n;
  // Energy table: config, active sign, gain, divisor, expected energy
  logic [3:0] t_cfg [8] = '{4'h0, 4'h4, 4'h4, 4'h8, 4'hC, 4'h0, 4'h0, 4'h0};
  logic t_neg [8] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
  logic [11:0] t_gain [8] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h800, 12'h400};
  logic [7:0] t_div [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h2, 8'h0, 8'h0};
  logic [23:0] t_exp [8] = '{24'hFFFFF5, 24'hFFFFF5, 24'hA, 24'hA, 24'hA, 24'h5, 24'h5, 24'hC};
  // Wave table: power, gain, offset, expected sample
  logic [23:0] w_pwr [4] = '{24'h1000, 24'h100, 24'h100, 24'h1000};
  logic [11:0] w_gain [4] = '{12'h800, 12'h0, 12'h0, 12'h400};
  logic [15:0] w_off [4] = '{16'h0, 16'h100, 16'hFF00, 16'h200};
  logic [23:0] w_exp [4] = '{24'h800, 24'h101, 24'hFF, 24'h1402};
  always #2.5 clk_i = ~clk_i;
  reactive_energy_accumulator dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
    .reactive_power_i(pwr), .active_power_neg_i(act_neg), .wave_data_o(wave),
    .wave_valid_o(wv), .irq_o(irq));
  core_bus_model core (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    err_count += core.timeouts;
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.wr(a, d);
    if (core.timeouts != 0)
      stop_test();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    core.rd(a, got);
    if (core.timeouts != 0)
      stop_test();
    chk(got, e);
  endtask
  // Interrupt line is looked at mid-cycle, clear of the edge updates
  task automatic irq_is(input logic e);
    @(negedge clk_i);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk_i);
  endtask
  task automatic step(input logic [23:0] p);
    pwr <= p;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic fresh();
    rst_i <= 1'h1;
    pwr <= 24'h000000;
    act_neg <= 1'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wave_wait();
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (wv !== 1'h1 && n < 17000);
    got = {8'h00, wave};
    if (n >= 17000)
    begin
      err_count++;
      stop_test();
    end
    @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    fresh();
    wr(IDX_DIVISOR, 32'h000000A5);
    rdc(IDX_DIVISOR, 32'h000000A5);
    rdc(8'h30, 32'h00000000);
    rdc(IDX_ENERGY, 32'h00000000);
    $display("Register test done");
    // 410 cycles give 82 ticks, so no tick lands on a rounding edge
    for (int i = 0; i < 8; i++)
    begin
      fresh();
      wr(IDX_ACC_CFG, {28'h0, t_cfg[i]});
      wr(IDX_GAIN, {20'h0, t_gain[i]});
      wr(IDX_DIVISOR, {24'h0, t_div[i]});
      act_neg <= t_neg[i];
      pwr <= (i < 5) ? 24'hC00000 : 24'h400000;
      repeat (410) @(posedge clk_i);
      pwr <= 24'h000000;
      repeat (10) @(posedge clk_i);
      rdc(IDX_ENERGY, {8'h0, t_exp[i]});
      rdc(IDX_ENERGY, {8'h0, t_exp[i]});
      rdc(IDX_ENERGY_RC, {8'h0, t_exp[i]});
      rdc(IDX_ENERGY, 32'h00000000);
    end
    rdc(IDX_IRQ_ST_MID, 32'h00000000);
    $display("Accumulation test done");
    fresh();
    wr(IDX_IRQ_EN_HIGH, 32'h00000020);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_GAIN, {20'h0, w_gain[i]});
      wr(IDX_OFFSET, {16'h0, w_off[i]});
      wr(IDX_WAVE_SEL, {31'h0, i == 3});
      pwr <= w_pwr[i];
      wave_wait();
      wave_wait();
      chk(got, {8'h0, w_exp[i]});
      chk(n, WAVE_BASE_DIV << (i == 3));
    end
    $display("Waveform test done");
    fresh();
    wr(IDX_IRQ_EN_LOW, 32'h00000012);
    step(24'h001000);
    step(24'hFFF000);
    rdc(IDX_IRQ_ST_LOW, 32'h00000010);
    irq_is(1'h1);
    wr(IDX_IRQ_ST_LOW, 32'h00000010);
    rdc(IDX_IRQ_ST_LOW, 32'h00000000);
    irq_is(1'h0);
    wr(IDX_ACC_CFG, 32'h00000020);
    step(24'h001000);
    rdc(IDX_IRQ_ST_LOW, 32'h00000010);
    wr(IDX_IRQ_ST_LOW, 32'h00000010);
    step(24'hFFF000);
    rdc(IDX_IRQ_ST_LOW, 32'h00000000);
    $display("Sign test done");
    for (int s = 0; s < 4; s++)
    begin
      fresh();
      wr(IDX_IRQ_EN_LOW, 32'h00000002);
      wr(IDX_NOLOAD_CFG, 32'(s << NL_LSB));
      step(24'h000010);
      rdc(IDX_IRQ_ST_LOW, (s != 0) ? 32'h00000002 : 32'h00000000);
      irq_is(s != 0);
      step(24'h400000);
      wr(IDX_IRQ_ST_LOW, 32'h00000002);
      rdc(IDX_IRQ_ST_LOW, 32'h00000000);
      irq_is(1'h0);
      // Level between the second and third threshold tells the selects apart
      step(24'h000060);
      wr(IDX_IRQ_ST_LOW, 32'h00000002);
      rdc(IDX_IRQ_ST_LOW, (s == 1 || s == 2) ? 32'h00000002 : 32'h00000000);
    end
    $display("No-load test done");
    stop_test();
  end
endmodule
`default_nettype wire
